//--- include/scic_pkg.sv
// Shared constants and types of the set/clear interrupt controller.
package scic_pkg;
	localparam int unsigned SCIC_NSRC = 32;
	localparam int unsigned SCIC_AW = 8;
	localparam int unsigned SCIC_DW = 32;

	// Register byte offsets; some offsets are shared by a read view and a write view.
	localparam logic [SCIC_AW-1:0] SCIC_TRIG_A_OFS = 8'h40;
	localparam logic [SCIC_AW-1:0] SCIC_TRIG_A_CLR_OFS = 8'h44;
	localparam logic [SCIC_AW-1:0] SCIC_TRIG_B_OFS = 8'h48;
	localparam logic [SCIC_AW-1:0] SCIC_TRIG_B_CLR_OFS = 8'h4c;
	localparam logic [SCIC_AW-1:0] SCIC_TRIG_C_OFS = 8'h50;
	localparam logic [SCIC_AW-1:0] SCIC_TRIG_C_CLR_OFS = 8'h54;
	localparam logic [SCIC_AW-1:0] SCIC_REQ0_OFS = 8'h54;
	localparam logic [SCIC_AW-1:0] SCIC_SRC_OFS = 8'h58;
	localparam logic [SCIC_AW-1:0] SCIC_SRC_CLR_OFS = 8'h5c;
	localparam logic [SCIC_AW-1:0] SCIC_REQ1_OFS = 8'h5c;
	localparam logic [SCIC_AW-1:0] SCIC_ROUTE_OFS = 8'h60;
	localparam logic [SCIC_AW-1:0] SCIC_ROUTE_CLR_OFS = 8'h64;
	localparam logic [SCIC_AW-1:0] SCIC_WAKE_OFS = 8'h68;
	localparam logic [SCIC_AW-1:0] SCIC_WAKE_CLR_OFS = 8'h6c;
	localparam logic [SCIC_AW-1:0] SCIC_ENABLE_OFS = 8'h70;
	localparam logic [SCIC_AW-1:0] SCIC_ENABLE_CLR_OFS = 8'h74;
	localparam logic [SCIC_AW-1:0] SCIC_RISE_OFS = 8'h78;
	localparam logic [SCIC_AW-1:0] SCIC_FALL_OFS = 8'h7c;
	localparam logic [SCIC_AW-1:0] SCIC_TEST_OFS = 8'h80;

	// Reset values of the per-source state and the test bit position.
	localparam logic [SCIC_NSRC-1:0] SCIC_VEC_RST = 32'h0000_0000;
	localparam logic [SCIC_DW-1:0] SCIC_DATA_ZERO = 32'h0000_0000;
	localparam int unsigned SCIC_TEST_BIT = 0;

	// Bus-request carrier built from the Avalon signals; acceptance is decided apart from it.
	typedef struct packed {
		logic [SCIC_AW-1:0] addr;
		logic rd;
		logic wr;
		logic [SCIC_DW-1:0] mask;
	} scic_bus_s;

	// Per-source decode of the three trigger-mode bits.
	typedef struct packed {
		logic [SCIC_NSRC-1:0] rise_en;
		logic [SCIC_NSRC-1:0] fall_en;
		logic [SCIC_NSRC-1:0] high_en;
		logic [SCIC_NSRC-1:0] low_en;
	} scic_trig_s;
endpackage

//--- rtl/scic_top.sv
// Set/clear interrupt controller with 32 sources and an Avalon-MM register slave.
//
// Summary of operation
// - Thirty-two sources; bit n of each per-source register governs source n.
// - All per-source registers are 32 bits wide; test register is not.
// - Read views return current state; a write at a read view's offset acts on the write view that shares that offset.
// - Set views force to one every bit written with one.
// - Clear views force to zero every bit written with one, except an edge latch bit that a new edge sets in the same cycle.
// - Reads and writes at offsets 0x54 and 0x5c decode to different registers.
// - Top bit zero: disabled, rising, falling, or both edges.
// - Top bit one: disabled, high level, low level, or everything.
// - Select bit zero takes the test bit, one takes the external line.
// - Test register holds one bit feeding every source selector.
// - Route bit zero steers to request one, one steers to request zero.
// - Request zero active vector is readable and zero after reset.
// - Request one active vector is readable and zero after reset.
// - Enable bit one passes, zero blocks; all zero after reset.
// - Wake bit lets an enabled interrupt leave idle; zero after reset.
// - Rising edges latch until software clears them via rising clear view.
// - Falling edges latch until software clears them via falling clear view.
// - Two request outputs, zero and one, go toward the processor.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
module scic_top
	import scic_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [SCIC_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [SCIC_DW-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [SCIC_DW-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [SCIC_NSRC-1:0] ext_src_line,
	output logic irq_req0,
	output logic irq_req1,
	output logic idle_wakeup
);
	scic_bus_s bus;
	scic_trig_s trig;
	logic waitrequest_q;
	logic [SCIC_DW-1:0] readdata_q;
	logic [SCIC_DW-1:0] rd_data;
	logic acc_wr;
	logic acc_rd_start;
	logic [SCIC_NSRC-1:0] trigger_mode_low_bit_q;
	logic [SCIC_NSRC-1:0] trigger_mode_mid_bit_q;
	logic [SCIC_NSRC-1:0] trigger_mode_top_bit_q;
	logic [SCIC_NSRC-1:0] source_select_q;
	logic [SCIC_NSRC-1:0] request_route_q;
	logic [SCIC_NSRC-1:0] idle_wakeup_enable_q;
	logic [SCIC_NSRC-1:0] source_enable_q;
	logic [SCIC_NSRC-1:0] rise_latch_q;
	logic [SCIC_NSRC-1:0] fall_latch_q;
	logic shared_test_bit_q;
	logic [SCIC_NSRC-1:0] sync1_q;
	logic [SCIC_NSRC-1:0] sync2_q;
	logic [SCIC_NSRC-1:0] prev_q;
	logic [SCIC_NSRC-1:0] sel_in;
	logic [SCIC_NSRC-1:0] rise_ev;
	logic [SCIC_NSRC-1:0] fall_ev;
	logic [SCIC_NSRC-1:0] active;
	logic [SCIC_NSRC-1:0] req0_vec;
	logic [SCIC_NSRC-1:0] req1_vec;
	logic [SCIC_NSRC-1:0] wake_vec;
	logic irq_req0_q;
	logic irq_req1_q;
	logic idle_wakeup_q;

	// Pack the bus request; byte enables become a per-bit write mask.
	assign bus.addr = avs_address;
	assign bus.rd = avs_read;
	assign bus.wr = avs_write;
	assign bus.mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & avs_writedata;

	// A write takes effect on the edge where the master sees waitrequest low.
	assign acc_wr = bus.wr && !waitrequest_q;
	// Read data is captured on the edge that drops waitrequest.
	assign acc_rd_start = bus.rd && waitrequest_q;

	// Waitrequest idles high and drops for exactly one cycle per request.
	// Holding it high by default keeps a new request from being taken twice.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			waitrequest_q <= 1'b1;
		end else if (!waitrequest_q) begin
			waitrequest_q <= 1'b1;
		end else if (bus.rd || bus.wr) begin
			waitrequest_q <= 1'b0;
		end
	end

	// Read decode; unmapped offsets and write-only offsets read as zero.
	always_comb begin
		rd_data = SCIC_DATA_ZERO;
		case (bus.addr)
			SCIC_TRIG_A_OFS: rd_data = trigger_mode_low_bit_q;
			SCIC_TRIG_B_OFS: rd_data = trigger_mode_mid_bit_q;
			SCIC_TRIG_C_OFS: rd_data = trigger_mode_top_bit_q;
			SCIC_REQ0_OFS: rd_data = req0_vec;
			SCIC_SRC_OFS: rd_data = source_select_q;
			SCIC_REQ1_OFS: rd_data = req1_vec;
			SCIC_ROUTE_OFS: rd_data = request_route_q;
			SCIC_WAKE_OFS: rd_data = idle_wakeup_enable_q;
			SCIC_ENABLE_OFS: rd_data = source_enable_q;
			SCIC_RISE_OFS: rd_data = rise_latch_q;
			SCIC_FALL_OFS: rd_data = fall_latch_q;
			SCIC_TEST_OFS: rd_data[SCIC_TEST_BIT] = shared_test_bit_q;
			default: rd_data = SCIC_DATA_ZERO;
		endcase
	end

	// Read data register, loaded once per read and held until the next one.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			readdata_q <= SCIC_DATA_ZERO;
		end else if (acc_rd_start) begin
			readdata_q <= rd_data;
		end
	end

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitrequest_q;

	// Trigger-mode bit registers; each has a set view and a clear view.
	// set by one
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trigger_mode_low_bit_q <= SCIC_VEC_RST;
			trigger_mode_mid_bit_q <= SCIC_VEC_RST;
			trigger_mode_top_bit_q <= SCIC_VEC_RST;
		end else if (acc_wr) begin
			case (bus.addr)
				SCIC_TRIG_A_OFS: trigger_mode_low_bit_q <= trigger_mode_low_bit_q | bus.mask;
				SCIC_TRIG_A_CLR_OFS: trigger_mode_low_bit_q <= trigger_mode_low_bit_q & ~bus.mask;
				SCIC_TRIG_B_OFS: trigger_mode_mid_bit_q <= trigger_mode_mid_bit_q | bus.mask;
				SCIC_TRIG_B_CLR_OFS: trigger_mode_mid_bit_q <= trigger_mode_mid_bit_q & ~bus.mask;
				SCIC_TRIG_C_OFS: trigger_mode_top_bit_q <= trigger_mode_top_bit_q | bus.mask;
				SCIC_TRIG_C_CLR_OFS: trigger_mode_top_bit_q <= trigger_mode_top_bit_q & ~bus.mask;
				default: begin
				end
			endcase
		end
	end

	// Source select and request routing registers.
	// set by one
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			source_select_q <= SCIC_VEC_RST;
			request_route_q <= SCIC_VEC_RST;
		end else if (acc_wr) begin
			case (bus.addr)
				SCIC_SRC_OFS: source_select_q <= source_select_q | bus.mask;
				// write at shared offset clears select
				SCIC_SRC_CLR_OFS: source_select_q <= source_select_q & ~bus.mask;
				SCIC_ROUTE_OFS: request_route_q <= request_route_q | bus.mask;
				SCIC_ROUTE_CLR_OFS: request_route_q <= request_route_q & ~bus.mask;
				default: begin
				end
			endcase
		end
	end

	// Enable and wake masks; both clear at reset so nothing fires unprogrammed.
	// enable mask register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			source_enable_q <= SCIC_VEC_RST;
			idle_wakeup_enable_q <= SCIC_VEC_RST;
		end else if (acc_wr) begin
			case (bus.addr)
				SCIC_ENABLE_OFS: source_enable_q <= source_enable_q | bus.mask;
				SCIC_ENABLE_CLR_OFS: source_enable_q <= source_enable_q & ~bus.mask;
				SCIC_WAKE_OFS: idle_wakeup_enable_q <= idle_wakeup_enable_q | bus.mask;
				SCIC_WAKE_CLR_OFS: idle_wakeup_enable_q <= idle_wakeup_enable_q & ~bus.mask;
				default: begin
				end
			endcase
		end
	end

	// Single read/write test bit; only byte lane zero reaches it.
	// test bit storage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shared_test_bit_q <= 1'b0;
		end else if (acc_wr && bus.addr == SCIC_TEST_OFS && avs_byteenable[0]) begin
			shared_test_bit_q <= avs_writedata[SCIC_TEST_BIT];
		end
	end

	// External lines come from another domain, so two flops precede any use.
	// Software must have made GPIO lines inputs with their pin function enabled.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_q <= SCIC_VEC_RST;
			sync2_q <= SCIC_VEC_RST;
		end else begin
			sync1_q <= ext_src_line;
			sync2_q <= sync1_q;
		end
	end

	assign sel_in = (source_select_q & sync2_q) |
		(~source_select_q & {SCIC_NSRC{shared_test_bit_q}});

	// Previous selected level, for edge detection after the mux.
	// Switching the selector may itself produce an edge; program it before enabling.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_q <= SCIC_VEC_RST;
		end else begin
			prev_q <= sel_in;
		end
	end

	// Trigger decode of {top, mid, low}.
	// edge modes
	assign trig.rise_en = trigger_mode_low_bit_q &
		(~trigger_mode_top_bit_q | trigger_mode_mid_bit_q);
	assign trig.fall_en = trigger_mode_mid_bit_q &
		(~trigger_mode_top_bit_q | trigger_mode_low_bit_q);
	assign trig.high_en = trigger_mode_top_bit_q & trigger_mode_low_bit_q;
	assign trig.low_en = trigger_mode_top_bit_q & trigger_mode_mid_bit_q;

	assign rise_ev = sel_in & ~prev_q & trig.rise_en;
	assign fall_ev = ~sel_in & prev_q & trig.fall_en;

	// Edge latches; a new edge wins over a clear written in the same cycle.
	// rising latch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rise_latch_q <= SCIC_VEC_RST;
			fall_latch_q <= SCIC_VEC_RST;
		end else begin
			if (acc_wr && bus.addr == SCIC_RISE_OFS) begin
				rise_latch_q <= (rise_latch_q & ~bus.mask) | rise_ev;
			end else begin
				rise_latch_q <= rise_latch_q | rise_ev;
			end
			if (acc_wr && bus.addr == SCIC_FALL_OFS) begin
				fall_latch_q <= (fall_latch_q & ~bus.mask) | fall_ev;
			end else begin
				fall_latch_q <= fall_latch_q | fall_ev;
			end
		end
	end

	// Active sources and the enabled, routed vectors.
	// active by level or latched edge
	assign active = (rise_latch_q & trig.rise_en) | (fall_latch_q & trig.fall_en) |
		(sel_in & trig.high_en) | (~sel_in & trig.low_en);
	assign req0_vec = active & source_enable_q & request_route_q;
	assign req1_vec = active & source_enable_q & ~request_route_q;
	assign wake_vec = active & source_enable_q & idle_wakeup_enable_q;

	// Registered outputs toward the core; one cycle behind the vectors.
	// two request outputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_req0_q <= 1'b0;
			irq_req1_q <= 1'b0;
			idle_wakeup_q <= 1'b0;
		end else begin
			irq_req0_q <= |req0_vec;
			irq_req1_q <= |req1_vec;
			idle_wakeup_q <= |wake_vec;
		end
	end

	assign irq_req0 = irq_req0_q;
	assign irq_req1 = irq_req1_q;
	assign idle_wakeup = idle_wakeup_q;

	// Bus handshake steps.
	sequence take_s;
		(bus.rd || bus.wr) && waitrequest_q;
	endsequence
	sequence ack_s;
		!waitrequest_q ##1 waitrequest_q;
	endsequence

	bus_handshake_a: assert property (@(posedge clk) disable iff (sys_rst)
		take_s |=> ack_s)
		else $error("Waitrequest did not pulse low for one cycle.");

	enable_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_wr && bus.addr == SCIC_ENABLE_OFS) |=>
		source_enable_q == ($past(source_enable_q) | $past(bus.mask)))
		else $error("Enable set view did not set written ones.");

	route_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_wr && bus.addr == SCIC_ROUTE_CLR_OFS) |=>
		request_route_q == ($past(request_route_q) & ~$past(bus.mask)))
		else $error("Route clear view did not clear written ones.");

	req1_view_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_wr && bus.addr == SCIC_REQ1_OFS) |=>
		$stable(request_route_q) && $stable(source_enable_q) && $stable(trigger_mode_top_bit_q))
		else $error("Write at shared offset touched an unrelated register.");

	req0_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_rd_start && bus.addr == SCIC_REQ0_OFS) |=> readdata_q == $past(req0_vec))
		else $error("Read at shared offset did not return request zero vector.");

	rise_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(rise_ev != SCIC_VEC_RST) |=> (rise_latch_q & $past(rise_ev)) == $past(rise_ev))
		else $error("Rising edge was not latched.");

	fall_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(fall_latch_q != SCIC_VEC_RST && !(acc_wr && bus.addr == SCIC_FALL_OFS)) |=>
		(fall_latch_q & $past(fall_latch_q)) == $past(fall_latch_q))
		else $error("Falling latch lost a bit without a clear.");

	route_out_a: assert property (@(posedge clk) disable iff (sys_rst)
		(|(active & source_enable_q & request_route_q)) |=> irq_req0_q)
		else $error("Source routed to request zero did not raise it.");

	enable_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		(source_enable_q == SCIC_VEC_RST) |=> !irq_req0_q && !irq_req1_q && !idle_wakeup_q)
		else $error("Request raised with all sources disabled.");

	wake_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		idle_wakeup_q |-> $past(|(active & source_enable_q & idle_wakeup_enable_q)))
		else $error("Wake raised without an enabled wake source.");

	test_select_a: assert property (@(posedge clk) disable iff (sys_rst)
		(~source_select_q & sel_in) == (~source_select_q & {SCIC_NSRC{shared_test_bit_q}}))
		else $error("Test bit did not feed an unselected source.");

	rise_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_wr && bus.addr == SCIC_RISE_OFS) |=>
		rise_latch_q == (($past(rise_latch_q) & ~$past(bus.mask)) | $past(rise_ev)))
		else $error("Rising clear view did not clear written ones.");

	fall_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_wr && bus.addr == SCIC_FALL_OFS) |=>
		fall_latch_q == (($past(fall_latch_q) & ~$past(bus.mask)) | $past(fall_ev)))
		else $error("Falling clear view did not clear written ones.");

	req1_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		(|(active & source_enable_q & ~request_route_q)) |=> irq_req1_q)
		else $error("Source routed to request one did not raise it.");

	req1_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_rd_start && bus.addr == SCIC_REQ1_OFS) |=> readdata_q == $past(req1_vec))
		else $error("Read at shared offset did not return request one vector.");

	test_store_a: assert property (@(posedge clk) disable iff (sys_rst)
		(acc_wr && bus.addr == SCIC_TEST_OFS && avs_byteenable[0]) |=>
		shared_test_bit_q == $past(avs_writedata[SCIC_TEST_BIT]))
		else $error("Test bit did not take the written value.");

	mode_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		(active & ~(trigger_mode_low_bit_q | trigger_mode_mid_bit_q)) == SCIC_VEC_RST)
		else $error("Disabled trigger mode let a source become active.");
endmodule

//--- tb/scic_src_model.sv
// Behavioural model of the peripheral and GPIO lines feeding the controller.
`timescale 1ns/10ps
module scic_src_model
	import scic_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [SCIC_NSRC-1:0] drive_lvl,
	output logic [SCIC_NSRC-1:0] ext_src_line
);
	// lines as inputs
	// The lines change just after a clock edge, like a registered peripheral output.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_src_line <= SCIC_VEC_RST;
		end else begin
			ext_src_line <= drive_lvl;
		end
	end
endmodule

//--- tb/tb_top.sv
// Register-level testbench of the set/clear interrupt controller.
`timescale 1ns/10ps
module tb_top
	import scic_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [SCIC_AW-1:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [SCIC_DW-1:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [SCIC_DW-1:0] avs_readdata;
	logic avs_waitrequest;
	logic [SCIC_NSRC-1:0] src_lvl = 32'h0000_0000;
	logic [SCIC_NSRC-1:0] ext_src_line;
	logic irq_req0;
	logic irq_req1;
	logic idle_wakeup;
	logic [SCIC_DW-1:0] rdat;
	logic [7:0] ofs [7] = '{8'h40, 8'h48, 8'h50, 8'h58, 8'h60, 8'h68, 8'h70};
	int num_errors = 0;
	int num_checks = 0;
	int cyc_cnt = 0;

	// Free-running clock of 10 ns period.
	always #5 clk = ~clk;

	scic_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_src_line(ext_src_line),
		.irq_req0(irq_req0), .irq_req1(irq_req1), .idle_wakeup(idle_wakeup));

	scic_src_model src (.clk(clk), .sys_rst(sys_rst), .drive_lvl(src_lvl),
		.ext_src_line(ext_src_line));

	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// A hung handshake would stall the sequence, so a cycle ceiling ends the run.
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: output %b, wanted %b", $time, got, exp);
		end
	endtask

	// Request is held until waitrequest is sampled low; data is taken at that edge.
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		chk_word(rdat, exp);
	endtask

	// Outputs are registered, so look a few cycles on, away from the edge.
	task automatic look;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		look;
		chk_bit(irq_req0, 1'b0);
		chk_bit(irq_req1, 1'b0);
		bus_rd(8'h54, 32'h0000_0000);
		bus_rd(8'h5c, 32'h0000_0000);
		bus_rd(8'h68, 32'h0000_0000);
		bus_rd(8'h70, 32'h0000_0000);
		// Every set/clear pair, with zero bits proving they leave state alone.
		for (int i = 0; i < 7; i++) begin
			bus_wr(ofs[i], 32'hf0f0_a5a5);
			bus_wr(ofs[i], 32'h0000_0000);
			bus_rd(ofs[i], 32'hf0f0_a5a5);
			bus_wr(ofs[i] + 8'h04, 32'h3000_0081);
			bus_rd(ofs[i], 32'hc0f0_a524);
			bus_wr(ofs[i] + 8'h04, 32'hffff_ffff);
			bus_rd(ofs[i], 32'h0000_0000);
		end
		bus_wr(8'h50, 32'hffff_ffff);
		bus_rd(8'h54, 32'h0000_0000);
		bus_wr(8'h54, 32'h0000_ffff);
		bus_rd(8'h50, 32'hffff_0000);
		bus_wr(8'h54, 32'hffff_ffff);
		bus_wr(8'h58, 32'hffff_ffff);
		bus_rd(8'h5c, 32'h0000_0000);
		bus_wr(8'h5c, 32'hffff_ffff);
		bus_rd(8'h58, 32'h0000_0000);
		bus_wr(8'h80, 32'hffff_ffff);
		bus_rd(8'h80, 32'h0000_0001);
		bus_wr(8'h80, 32'h0000_0000);
		bus_wr(8'h00, 32'hffff_ffff);
		bus_rd(8'h00, 32'h0000_0000);
		avs_byteenable <= 4'h1;
		bus_wr(8'h70, 32'hffff_ffff);
		avs_byteenable <= 4'hf;
		bus_rd(8'h70, 32'h0000_00ff);
		// Source n gets mode n, all fed from the test bit and routed to request 0.
		bus_wr(8'h40, 32'h0000_00aa);
		bus_wr(8'h48, 32'h0000_00cc);
		bus_wr(8'h50, 32'h0000_00f0);
		bus_wr(8'h60, 32'h0000_00ff);
		bus_rd(8'h54, 32'h0000_00c0);
		look;
		chk_bit(irq_req0, 1'b1);
		chk_bit(irq_req1, 1'b0);
		bus_wr(8'h80, 32'h0000_0001);
		bus_rd(8'h78, 32'h0000_008a);
		bus_rd(8'h54, 32'h0000_00aa);
		bus_wr(8'h80, 32'h0000_0000);
		bus_rd(8'h7c, 32'h0000_008c);
		bus_rd(8'h78, 32'h0000_008a);
		bus_rd(8'h54, 32'h0000_00ce);
		bus_wr(8'h78, 32'h0000_0002);
		bus_wr(8'h7c, 32'hffff_ffff);
		bus_rd(8'h78, 32'h0000_0088);
		bus_rd(8'h7c, 32'h0000_0000);
		bus_rd(8'h54, 32'h0000_00c8);
		bus_wr(8'h64, 32'h0000_0008);
		bus_rd(8'h54, 32'h0000_00c0);
		bus_rd(8'h5c, 32'h0000_0008);
		look;
		chk_bit(irq_req1, 1'b1);
		chk_bit(idle_wakeup, 1'b0);
		bus_wr(8'h68, 32'h0000_0040);
		look;
		chk_bit(idle_wakeup, 1'b1);
		bus_wr(8'h74, 32'h0000_0040);
		look;
		chk_bit(idle_wakeup, 1'b0);
		bus_rd(8'h54, 32'h0000_0080);
		// Source 8 takes its external line; source 1 stays on the test bit.
		bus_wr(8'h40, 32'h0000_0100);
		bus_wr(8'h50, 32'h0000_0100);
		bus_wr(8'h58, 32'h0000_0100);
		bus_wr(8'h60, 32'h0000_0100);
		bus_wr(8'h70, 32'h0000_0100);
		// Source 7 is disabled so that request 0 depends on source 8 alone.
		bus_wr(8'h74, 32'h0000_0080);
		look;
		chk_bit(irq_req0, 1'b0);
		@(posedge clk);
		src_lvl <= 32'h0000_0102;
		look;
		look;
		chk_bit(irq_req0, 1'b1);
		bus_rd(8'h54, 32'h0000_0100);
		bus_rd(8'h78, 32'h0000_0088);
		@(posedge clk);
		src_lvl <= 32'h0000_0000;
		look;
		look;
		chk_bit(irq_req0, 1'b0);
		bus_rd(8'h54, 32'h0000_0000);
		wrap_up;
	end
endmodule
